// *** design/rfam_map.sv ***
// Purpose: program memory and register file address decode with page,
//          bank and slice pointer state
// Assumes: cpu core on same clock; one register access per cycle
// Notes:   decode results are registered, so they follow the request by one cycle
// Operation
// - program memory addressed on 16 bits; register file on separate 8-bit bus
// - 0000-00ff hold vectors; unused cells besides options stay normal memory
// - after reset fetch starts at program address 0100
// - start-up options come from 003e and 003f; 003c/003d unused (code still flags 003c/003d in pm_opt_hit and stores writes to them)
// - program writes to option cells change bytes, not active options
// - set 1 e0-ff duplicated as bank 0 and bank 1, chosen by instructions
// - reset selects bank 0
// - page select at df: low nibble source, high nibble destination, reset zero
// - c0-ff is set 1 for direct mode, set 2 for indirect or indexed
// - set 2 exists on pages 0 through 7
// - prime area 00-bf reachable in every mode, paged by page select
// - slice is eight bytes sharing top five bits; two pointers form block
// - working register addressing never reaches set 2
// - reset points slices at c0-c7 and c8-cf
// - common area c0-cf reachable only by working register addressing
// - system registers at d0-df in lower half of set 1
// - working number top bit picks pointer; pointer top five plus low three
// - slice pointers mapped at d6 and d7 in set 1
// - register pair starts even; even holds msb, odd holds lsb
`timescale 1ns/1ps
`include "rfam_regs.svh"
module rfam_map
  import rfam_pkg::*;
#(
  parameter int PM_AW = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [PM_AW-1:0] pm_addr,
  input  wire logic             pm_wr,
  input  wire logic [7:0]       pm_wdata,
  input  wire logic             pm_fetch_next,
  input  wire logic             rf_req,
  input  wire logic             rf_wr,
  input  wire logic [7:0]       rf_addr,
  input  wire logic [1:0]       rf_mode,
  input  wire logic [3:0]       rf_wnum,
  input  wire logic             rf_pair,
  input  wire logic [7:0]       rf_wdata,
  input  wire logic             choose_bank_zero_instr,
  input  wire logic             choose_bank_one_instr,
  output logic [PM_AW-1:0]      pm_fetch_addr,
  output logic                  pm_vec_area,
  output logic                  pm_opt_hit,
  output logic [15:0]           startup_options,
  output logic [10:0]           rf_phys_addr,
  output logic [3:0]            rf_target,
  output logic                  rf_illegal,
  output logic                  rf_pair_lsb_next,
  output logic [7:0]            rf_rdata,
  output logic                  bank_sel,
  output logic [7:0]            register_page_select,
  output logic [7:0]            first_slice_pointer,
  output logic [7:0]            second_slice_pointer
);

  // storage for the option cells so writes land but do not steer start-up
  logic [7:0]       opt_cell_ff [0:3];
  logic [15:0]      opt_live_ff;
  logic [PM_AW-1:0] pc_ff;
  logic             bank_ff;
  logic [7:0]       page_ff;
  logic [7:0]       rp0_ff;
  logic [7:0]       rp1_ff;
  logic [10:0]      phys_ff;
  logic [3:0]       tgt_ff;
  logic             ill_ff;
  logic             pair_ff;
  logic [7:0]       rdata_ff;
  logic             vec_ff;
  logic             opth_ff;
  rfam_st_e         st_ff;
  rfam_st_e         nxt_st;
  logic [PM_AW-1:0] nxt_pc;
  logic [15:0]      nxt_opt_live;
  logic             nxt_bank;
  logic [7:0]       nxt_page;
  logic [7:0]       nxt_rp0;
  logic [7:0]       nxt_rp1;
  logic [10:0]      nxt_phys;
  logic [3:0]       nxt_tgt;
  logic             nxt_ill;
  logic             nxt_pair;
  logic [7:0]       nxt_rdata;
  logic             nxt_vec;
  logic             nxt_opth;

  function automatic logic [7:0] rfam_wr_addr(input logic [3:0] num,
                                              input logic [7:0] p0,
                                              input logic [7:0] p1);
    logic [7:0] p;
    p = num[3] ? p1 : p0;
    rfam_wr_addr = {p[`RFAM_SLICE_HI:`RFAM_SLICE_LO], num[2:0]};
  endfunction

  function automatic logic in_upper(input logic [7:0] a);
    in_upper = (a >= `RFAM_RF_SET_BASE);
  endfunction

  wire [PM_AW-1:0] pm_a     = pm_addr;
  wire             vec_hit  = (pm_a <= PM_AW'(`RFAM_PM_VEC_TOP));
  wire             opt_rng  = (pm_a >= PM_AW'(`RFAM_PM_OPT_FIRST)) &&
                              (pm_a <= PM_AW'(`RFAM_PM_OPT_HI));
  wire [1:0]       opt_idx  = pm_a[1:0];
  wire [PM_AW-1:0] opt_hi_a = PM_AW'(`RFAM_PM_OPT_HI);
  wire [PM_AW-1:0] opt_lo_a = PM_AW'(`RFAM_PM_OPT_LO);

  // mode class arrives with every access
  wire             is_work  = (rf_mode == RFAM_MODE_WORKING);
  wire             is_dir   = (rf_mode == RFAM_MODE_DIRECT);
  wire             is_ind   = (rf_mode == RFAM_MODE_INDIRECT) ||
                              (rf_mode == RFAM_MODE_INDEXED);
  wire [7:0]       eff_a    = is_work ? rfam_wr_addr(rf_wnum, rp0_ff, rp1_ff) : rf_addr;
  wire             upper    = in_upper(eff_a);
  // common area only through working registers
  wire             common   = (eff_a < `RFAM_RF_SYS_BASE) && upper;
  wire             ill_com  = common && is_dir;
  // set steering; working mode forced to set 1
  wire             to_set2  = upper && is_ind;
  // source page for reads, destination page for writes
  wire [3:0]       page_use = rf_wr ? page_ff[7:4] : page_ff[3:0];
  // set 2 only on pages 0..7
  wire             ill_s2   = to_set2 && (page_use >= 4'(`RFAM_SET2_PAGES));
  // bank applies in e0-ff of set 1
  wire             banked   = upper && !to_set2 && (eff_a >= `RFAM_RF_BANK_BASE);
  wire [10:0]      phys     = !upper  ? {page_use[2:0], eff_a} :
                              to_set2 ? {page_use[2:0], eff_a} :
                              {2'h0, banked & bank_ff, eff_a};
  wire [3:0]       tgt      = (ill_com || ill_s2) ? RFAM_TGT_NONE :
                              !upper ? RFAM_TGT_PRIME :
                              to_set2 ? RFAM_TGT_SET2 : RFAM_TGT_SET1;
  wire             sys_acc  = rf_req && upper && !to_set2 && !is_ind;
  wire             wr_pp    = sys_acc && rf_wr && (eff_a == `RFAM_RF_PAGE_SEL);
  wire             wr_rp0   = sys_acc && rf_wr && (eff_a == `RFAM_RF_SLICE0);
  wire             wr_rp1   = sys_acc && rf_wr && (eff_a == `RFAM_RF_SLICE1);
  wire [7:0]       rd_val   = (eff_a == `RFAM_RF_PAGE_SEL) ? page_ff :
                              (eff_a == `RFAM_RF_SLICE0)   ? rp0_ff  :
                              (eff_a == `RFAM_RF_SLICE1)   ? rp1_ff  : 8'h00;
  // pair starts even, lsb follows at odd
  wire             pair_ok  = rf_pair && !eff_a[0];

  // fetch pointer holds still in the boot cycle
  assign nxt_pc       = (st_ff == RFAM_ST_RUN && pm_fetch_next) ? pc_ff + PM_AW'(1) : pc_ff;
  // live options follow the cells only in the boot cycle
  assign nxt_opt_live = (st_ff == RFAM_ST_BOOT) ?
                        {opt_cell_ff[opt_hi_a[1:0]], opt_cell_ff[opt_lo_a[1:0]]} :
                        opt_live_ff;
  // bank one wins when both pulses arrive together
  assign nxt_bank     = choose_bank_one_instr  ? 1'b1 :
                        choose_bank_zero_instr ? 1'b0 : bank_ff;
  assign nxt_page     = wr_pp  ? rf_wdata : page_ff;
  assign nxt_rp0      = wr_rp0 ? rf_wdata : rp0_ff;
  assign nxt_rp1      = wr_rp1 ? rf_wdata : rp1_ff;
  // address holds between requests so a slow reader still sees the last one
  assign nxt_phys     = rf_req ? phys : phys_ff;
  assign nxt_tgt      = rf_req ? tgt : RFAM_TGT_NONE;
  assign nxt_ill      = rf_req && (ill_com || ill_s2);
  assign nxt_pair     = rf_req && pair_ok;
  assign nxt_rdata    = (sys_acc && !rf_wr) ? rd_val : 8'h00;
  assign nxt_vec      = vec_hit;
  assign nxt_opth     = opt_rng;

  // one cycle after reset the fetch pointer is parked at the reset address
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      RFAM_ST_BOOT: nxt_st = RFAM_ST_RUN;
      RFAM_ST_RUN:  nxt_st = RFAM_ST_RUN;
      default:      nxt_st = RFAM_ST_BOOT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= RFAM_ST_BOOT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_ff <= PM_AW'(`RFAM_PM_RESET_ADDR);
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // cell writes stored; live options latched only at reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        opt_cell_ff[i] <= `RFAM_OPT_CELL_RST;
      end
    end else if (pm_wr && opt_rng) begin
      opt_cell_ff[opt_idx] <= pm_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opt_live_ff <= `RFAM_OPT_RST;
    end else begin
      opt_live_ff <= nxt_opt_live;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_ff <= 1'b0;
    end else begin
      bank_ff <= nxt_bank;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_ff <= `RFAM_PAGE_SEL_RST;
    end else begin
      page_ff <= nxt_page;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rp0_ff <= `RFAM_SLICE0_RST;
    end else begin
      rp0_ff <= nxt_rp0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rp1_ff <= `RFAM_SLICE1_RST;
    end else begin
      rp1_ff <= nxt_rp1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phys_ff <= 11'h000;
    end else begin
      phys_ff <= nxt_phys;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgt_ff <= RFAM_TGT_NONE;
    end else begin
      tgt_ff <= nxt_tgt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ill_ff <= 1'b0;
    end else begin
      ill_ff <= nxt_ill;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pair_ff <= 1'b0;
    end else begin
      pair_ff <= nxt_pair;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec_ff <= 1'b0;
    end else begin
      vec_ff <= nxt_vec;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opth_ff <= 1'b0;
    end else begin
      opth_ff <= nxt_opth;
    end
  end

  assign pm_fetch_addr        = pc_ff;
  assign pm_vec_area          = vec_ff;
  assign pm_opt_hit           = opth_ff;
  assign startup_options      = opt_live_ff;
  assign rf_phys_addr         = phys_ff;
  assign rf_target            = tgt_ff;
  assign rf_illegal           = ill_ff;
  assign rf_pair_lsb_next     = pair_ff;
  assign rf_rdata             = rdata_ff;
  assign bank_sel             = bank_ff;
  assign register_page_select = page_ff;
  assign first_slice_pointer  = rp0_ff;
  assign second_slice_pointer = rp1_ff;

endmodule

// *** design/rfam_pkg.sv ***
// Purpose: types for the register file address map block
// Assumes: nothing beyond the constants header
// Notes:   mode and target encodings are shared with the bench
package rfam_pkg;
  typedef enum logic [1:0] {
    RFAM_MODE_DIRECT   = 2'h0,
    RFAM_MODE_WORKING  = 2'h1,
    RFAM_MODE_INDIRECT = 2'h2,
    RFAM_MODE_INDEXED  = 2'h3
  } rfam_mode_e;
  typedef enum logic [3:0] {
    RFAM_TGT_PRIME = 4'h1,
    RFAM_TGT_SET1  = 4'h2,
    RFAM_TGT_SET2  = 4'h4,
    RFAM_TGT_NONE  = 4'h8
  } rfam_tgt_e;
  typedef enum logic [1:0] {
    RFAM_ST_BOOT = 2'h1,
    RFAM_ST_RUN  = 2'h2
  } rfam_st_e;
endpackage

// *** design/rfam_regs.svh ***
// Purpose: constants for the register file address map block
// Assumes: 8-bit register bus, 16-bit program address bus
// Notes:   offsets, reset values and field positions
`ifndef RFAM_REGS_SVH
`define RFAM_REGS_SVH
`define RFAM_PM_VEC_TOP      16'h00ff
`define RFAM_PM_RESET_ADDR   16'h0100
`define RFAM_PM_OPT_FIRST    16'h003c
`define RFAM_PM_OPT_LO       16'h003e
`define RFAM_PM_OPT_HI       16'h003f
`define RFAM_RF_SET_BASE     8'hc0
`define RFAM_RF_SYS_BASE     8'hd0
`define RFAM_RF_BANK_BASE    8'he0
`define RFAM_RF_PAGE_SEL     8'hdf
`define RFAM_RF_SLICE0       8'hd6
`define RFAM_RF_SLICE1       8'hd7
`define RFAM_PAGE_SEL_RST    8'h00
`define RFAM_SLICE0_RST      8'hc0
`define RFAM_SLICE1_RST      8'hc8
`define RFAM_OPT_RST         16'hffff
`define RFAM_OPT_CELL_RST    8'hff
`define RFAM_SLICE_HI        7
`define RFAM_SLICE_LO        3
`define RFAM_SET2_PAGES      8
`endif

// *** verif/rfam_cpu_model.sv ***
// Purpose: cpu core model on the program and register buses
// Assumes: one access per call, lines change 1 ns after the edge
// Notes:   released register address and data lines show inverted values so stale data cannot pass
`timescale 1ns/1ps
module rfam_cpu_model (
  input  wire logic   clk,
  output logic [15:0] pm_addr,
  output logic        pm_wr,
  output logic [7:0]  pm_wdata,
  output logic        pm_fetch_next,
  output logic        rf_req,
  output logic        rf_wr,
  output logic [7:0]  rf_addr,
  output logic [1:0]  rf_mode,
  output logic [3:0]  rf_wnum,
  output logic        rf_pair,
  output logic [7:0]  rf_wdata,
  output logic        choose_bank_zero_instr,
  output logic        choose_bank_one_instr
);
  initial {pm_addr, pm_wr, pm_wdata, pm_fetch_next, rf_req, rf_wr, rf_addr, rf_mode, rf_wnum,
    rf_pair, rf_wdata, choose_bank_zero_instr, choose_bank_one_instr} = '0;
  task automatic rf(input logic [1:0] m, input logic [7:0] a, input logic w = 1'b0,
    input logic [7:0] d = 8'h00, input logic [3:0] n = 4'h0, input logic p = 1'b0);
    @(posedge clk);
    #1 {rf_req, rf_mode, rf_addr, rf_wr, rf_wdata, rf_wnum, rf_pair} = {1'b1, m, a, w, d, n, p};
    @(posedge clk);
    #1 {rf_req, rf_addr, rf_wdata} = {1'b0, ~a, ~d};
  endtask
  // s is {write, fetch, bank zero, bank one}; the address stays as a level
  task automatic pu(input logic [15:0] a, input logic [3:0] s);
    @(posedge clk);
    #1 {pm_addr, pm_wdata, pm_wr, pm_fetch_next, choose_bank_zero_instr,
      choose_bank_one_instr} = {a, ~a[7:0], s};
    @(posedge clk);
    #1 {pm_wr, pm_fetch_next, choose_bank_zero_instr, choose_bank_one_instr} = 4'h0;
  endtask
endmodule

// *** verif/rfam_map_assertions.sv ***
// Purpose: port checks for rfam_map
// Assumes: one clock, synchronous active-low reset
// Notes:   decode answers lag the taking edge by one cycle
`timescale 1ns/1ps
module rfam_map_chk import rfam_pkg::*; #(parameter int PM_AW = 16) (
  input logic             clk,
  input logic             rst_n,
  input logic             rf_req,
  input logic             rf_wr,
  input logic [7:0]       rf_addr,
  input logic [1:0]       rf_mode,
  input logic             choose_bank_one_instr,
  input logic [PM_AW-1:0] pm_fetch_addr,
  input logic [10:0]      rf_phys_addr,
  input logic [3:0]       rf_target,
  input logic             rf_illegal,
  input logic             bank_sel,
  input logic [7:0]       register_page_select,
  input logic [7:0]       first_slice_pointer,
  input logic [7:0]       second_slice_pointer
);
  // $past only takes whole signals, so the paged address is kept here
  logic [10:0] exp_prime_ff;
  always_ff @(posedge clk) exp_prime_ff <= {register_page_select[2:0], rf_addr};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_state: assert property ($rose(rst_n) |-> pm_fetch_addr == 16'h0100
    && !bank_sel && register_page_select == 8'h00) else $error("reset state");
  chk_reset_slices: assert property ($rose(rst_n) |-> first_slice_pointer == 8'hc0
    && second_slice_pointer == 8'hc8) else $error("reset slices");
  chk_direct_common: assert property (rf_req && rf_mode == RFAM_MODE_DIRECT
    && rf_addr[7:4] == 4'hc |=> rf_illegal && rf_target == RFAM_TGT_NONE) else $error("common");
  chk_illegal_none: assert property (rf_illegal |-> rf_target == RFAM_TGT_NONE)
    else $error("illegal target");
  chk_set2_steer: assert property (rf_req && !rf_wr && rf_mode[1] && rf_addr[7:6] == 2'h3
    && !register_page_select[3] |=> rf_target == RFAM_TGT_SET2) else $error("set2");
  chk_prime_page: assert property (rf_req && !rf_wr && rf_mode != RFAM_MODE_WORKING
    && rf_addr < 8'hc0 && !register_page_select[3] |=> rf_target == RFAM_TGT_PRIME
    && rf_phys_addr == exp_prime_ff) else $error("prime");
  chk_work_no_set2: assert property (rf_req && rf_mode == RFAM_MODE_WORKING
    |=> rf_target != RFAM_TGT_SET2) else $error("working set2");
  chk_bank_one: assert property (choose_bank_one_instr |=> bank_sel) else $error("bank");
  cover property (rf_req && rf_mode == RFAM_MODE_INDEXED ##1 rf_target == RFAM_TGT_SET2);
  cover property (rf_illegal);
  cover property (choose_bank_one_instr ##1 bank_sel);
endmodule
bind rfam_map rfam_map_chk #(.PM_AW(PM_AW)) u_chk (.*);

// *** verif/test_register_file_address_map.sv ***
// Purpose: directed test of rfam_map through the cpu model
// Assumes: answers one cycle after the taking edge
// Notes:   calls leave an idle cycle, so back-to-back is not exercised
`timescale 1ns/1ps
module test_register_file_address_map import rfam_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] pm_addr, pm_fetch_addr, startup_options;
  logic [10:0] rf_phys_addr;
  logic [7:0]  pm_wdata, rf_addr, rf_wdata, rf_rdata, register_page_select;
  logic [7:0]  first_slice_pointer, second_slice_pointer;
  logic [3:0]  rf_wnum, rf_target;
  logic [1:0]  rf_mode;
  logic        pm_wr, pm_fetch_next, rf_req, rf_wr, rf_pair, choose_bank_zero_instr, bank_sel;
  logic        choose_bank_one_instr, pm_vec_area, pm_opt_hit, rf_illegal, rf_pair_lsb_next;
  int          num_errors = 0;
  int          cmp_count = 0;
  always #50 clk = ~clk;
  rfam_cpu_model cpu (.*);
  rfam_map dut (.*);
  task automatic ck(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // modes: 0 direct, 1 working, 2 indirect, 3 indexed
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    ck("fetch", 16'h0100, pm_fetch_addr);
    ck("page bank", 16'h0000, {register_page_select, 7'h0, bank_sel});
    ck("slices", 16'hc0c8, {first_slice_pointer, second_slice_pointer});
    ck("options", 16'hffff, startup_options);
    cpu.rf(2'h0, 8'hdf, 1'b1, 8'h21);
    cpu.rf(2'h0, 8'hdf);
    ck("page rd", 16'h0021, rf_rdata);
    cpu.rf(2'h2, 8'h10);
    ck("prime", 16'h1110, {rf_target, 1'b0, rf_phys_addr});
    for (int p = 0; p < 9; p++) begin
      cpu.rf(2'h0, 8'hdf, 1'b1, 8'(p));
      cpu.rf(2'h3, 8'he0);
      ck("set2", (p < 8) ? RFAM_TGT_SET2 : RFAM_TGT_NONE, rf_target);
    end
    cpu.rf(2'h0, 8'hdf, 1'b1, 8'h00);
    cpu.rf(2'h0, 8'hc3);
    ck("common", 16'h8001, {rf_target, 11'h0, rf_illegal});
    cpu.rf(2'h1, 8'h00, 1'b0, 8'h00, 4'h3);
    ck("work c3", 16'h20c3, {rf_target, 1'b0, rf_phys_addr});
    cpu.rf(2'h0, 8'hd6);
    ck("ptr rd", 16'h00c0, rf_rdata);
    cpu.rf(2'h0, 8'hd0);
    ck("sys", RFAM_TGT_SET1, rf_target);
    cpu.rf(2'h0, 8'hd7, 1'b1, 8'h48);
    cpu.rf(2'h1, 8'h00, 1'b0, 8'h00, 4'h9);
    ck("work 49", 16'h1049, {rf_target, 1'b0, rf_phys_addr});
    cpu.rf(2'h0, 8'hd6, 1'b1, 8'hf8);
    cpu.rf(2'h1, 8'h00, 1'b0, 8'h00, 4'h3);
    ck("work fb", 16'h20fb, {rf_target, 1'b0, rf_phys_addr});
    cpu.pu(16'h0100, 4'h1);
    cpu.rf(2'h0, 8'he4);
    ck("bank one", 16'h21e4, {rf_target, 1'b0, rf_phys_addr});
    cpu.pu(16'h0100, 4'h2);
    ck("bank zero", 16'h0000, bank_sel);
    cpu.rf(2'h0, 8'h20, 1'b0, 8'h00, 4'h0, 1'b1);
    ck("pair even", 16'h0001, rf_pair_lsb_next);
    cpu.rf(2'h0, 8'h21, 1'b0, 8'h00, 4'h0, 1'b1);
    ck("pair odd", 16'h0000, rf_pair_lsb_next);
    cpu.pu(16'h003e, 4'h8);
    ck("opt cell", 16'h0003, {pm_vec_area, pm_opt_hit});
    ck("opt keep", 16'hffff, startup_options);
    cpu.pu(16'h0100, 4'h4);
    ck("fetch next", 16'h0101, pm_fetch_addr);
    ck("vec out", 16'h0000, {pm_vec_area, pm_opt_hit});
    cpu.pu(16'h0100, 4'h1);
    cpu.rf(2'h0, 8'hdf, 1'b1, 8'h35);
    ck("pre rst", 16'h3501, {register_page_select, 7'h0, bank_sel});
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    ck("rst fetch", 16'h0100, pm_fetch_addr);
    ck("rst page bank", 16'h0000, {register_page_select, 7'h0, bank_sel});
    ck("rst slices", 16'hc0c8, {first_slice_pointer, second_slice_pointer});
    ck("rst options", 16'hffff, startup_options);
    cpu.rf(2'h1, 8'h00, 1'b0, 8'h00, 4'hb);
    ck("rst work cb", 16'h20cb, {rf_target, 1'b0, rf_phys_addr});
    end_of_test();
  end
endmodule
